// ---- plrs_pkg.sv ----
// package of constants and carrier types for the panel lockout and reference status block
//
// Overview of operation
// - one second hold locks an enabled panel
// - configured inactivity timeout locks the panel
// - three second hold re-enables the panel
// - re-enable restarts the inactivity timeout count
// - enable lamp lit exactly while panel enabled
// - internal reference lamp steady when internal used
// - external lamp steady when external reference locked
// - external lamp blinks when external lock fails
// - fan warning relocks five minutes after activity
package plrs_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CLK_FREQ_HZ    = 100_000_000;        // system clock rate
	localparam int unsigned LOCK_HOLD_MS   = 1000;               // hold time to lock
	localparam int unsigned UNLOCK_HOLD_MS = 3000;               // hold time to unlock
	localparam int unsigned FAN_IDLE_S     = 300;                // five minutes
	localparam int unsigned DEBOUNCE_US    = 10_000;             // contact bounce filter
	localparam int unsigned BLINK_HALF_MS  = 250;                // blink half period
	localparam int unsigned TICK_US        = 1000;               // millisecond tick
	localparam int unsigned TICK_CYCLES    = CLK_FREQ_HZ / 1_000_000 * TICK_US;
	localparam int unsigned DEBOUNCE_MS    = DEBOUNCE_US / TICK_US;
	localparam int unsigned FAN_IDLE_MS    = FAN_IDLE_S * 1000;
	localparam int unsigned MS_W           = 32;                 // millisecond counter width

	// ****************************************************************
	// carrier types
	// ****************************************************************
	// reference status from the lock detector
	typedef struct packed {
		logic ext_selected;                                  // external reference chosen
		logic ext_locked;                                    // lock achieved
	} plrs_ref_t;

	// lamp outputs
	typedef struct packed {
		logic enable_lamp;                                   // lamp beside lock button
		logic internal_ref_lamp;                             // internal reference lamp
		logic external_ref_lamp;                             // external reference lamp
	} plrs_lamps_t;

	// panel lock state
	typedef enum logic [0:0] {
		PLRS_LOCKED  = 1'b0,
		PLRS_ENABLED = 1'b1
	} plrs_state_t;

endpackage

// ---- plrs_panel_lockout.sv ----
// panel lockout controller with reference status lamps
`timescale 1ns/1ps

module plrs_panel_lockout
	import plrs_pkg::*;
#(
	parameter int unsigned LOCK_MS     = LOCK_HOLD_MS,         // lock hold, ms
	parameter int unsigned UNLOCK_MS   = UNLOCK_HOLD_MS,       // unlock hold, ms
	parameter int unsigned FAN_MS      = FAN_IDLE_MS,          // fan relock idle, ms
	parameter int unsigned TICK_CYC    = TICK_CYCLES           // cycles per ms tick
)
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// front panel buttons (raw pins)
	input  wire logic        lock_button,                      // lock/unlock button, high pressed
	input  wire logic        any_button,                       // any other button pressed
	// configuration and status from the instrument
	input  wire logic [31:0] timeout_ms,                       // inactivity period, 0 = none
	input  wire logic        fan_fail,                         // fan failure warning
	input  wire plrs_ref_t   ref_status,                       // reference detector
	// outputs
	output plrs_lamps_t      lamps,                            // lamp drive
	output logic             panel_enabled                     // buttons accepted
);

	// ****************************************************************
	// parameter checks
	// ****************************************************************
	if (LOCK_MS == 0 || UNLOCK_MS <= LOCK_MS || TICK_CYC < 2 || FAN_MS == 0)
		$error("plrs_panel_lockout: unsupported timing parameters");

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	logic [4:0] sync1_q;                                       // first stage, read only by second
	logic [4:0] sync2_q;                                       // second stage
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
		end
		else
		begin
			sync1_q <= {lock_button, any_button, fan_fail, ref_status.ext_selected,
				ref_status.ext_locked};
			sync2_q <= sync1_q;
		end
	end
	logic lock_s;
	logic any_s;
	logic fan_s;
	plrs_ref_t ref_s;
	assign lock_s           = sync2_q[4];
	assign any_s            = sync2_q[3];
	assign fan_s            = sync2_q[2];
	assign ref_s            = sync2_q[1:0];

	// ****************************************************************
	// millisecond tick
	// ****************************************************************
	logic [31:0] tick_cnt_q;
	logic        tick_q;                                       // one cycle per ms
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tick_cnt_q <= 32'h0;
			tick_q     <= 1'b0;
		end
		else if (tick_cnt_q == TICK_CYC - 1)
		begin
			tick_cnt_q <= 32'h0;
			tick_q     <= 1'b1;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 32'h1;
			tick_q     <= 1'b0;
		end
	end

	// ****************************************************************
	// debounce of the lock button
	// ****************************************************************
	// state changes only after the raw level stays put for the filter time
	logic [7:0] db_cnt_q;
	logic       lock_db_q;                                     // debounced press
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			db_cnt_q  <= 8'h00;
			lock_db_q <= 1'b0;
		end
		else if (lock_s == lock_db_q)
			db_cnt_q <= 8'h00;
		else if (tick_q)
		begin
			if (db_cnt_q >= 8'(DEBOUNCE_MS))
			begin
				lock_db_q <= lock_s;
				db_cnt_q  <= 8'h00;
			end
			else
				db_cnt_q <= db_cnt_q + 8'h01;
		end
	end

	// other buttons are only activity hints; a bounce merely restarts the timer twice
	logic any_prev_q;
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			any_prev_q <= 1'b0;
		else
			any_prev_q <= any_s;
	end
	logic press_evt;
	assign press_evt = any_s & ~any_prev_q;

	// ****************************************************************
	// hold timer; one action per press
	// ****************************************************************
	logic [MS_W-1:0] hold_ms_q;
	logic            hold_done_q;                              // action taken this press
	logic            hold_lock;
	logic            hold_unlock;
	plrs_state_t     state_q;
	assign hold_lock   = lock_db_q & ~hold_done_q & (state_q == PLRS_ENABLED)
		& (hold_ms_q >= MS_W'(LOCK_MS));
	assign hold_unlock = lock_db_q & ~hold_done_q & (state_q == PLRS_LOCKED)
		& (hold_ms_q >= MS_W'(UNLOCK_MS));
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hold_ms_q   <= '0;
			hold_done_q <= 1'b0;
		end
		else if (!lock_db_q)
		begin
			// release before threshold just clears the timer
			hold_ms_q   <= '0;
			hold_done_q <= 1'b0;
		end
		else
		begin
			if (tick_q && !hold_done_q)
				hold_ms_q <= hold_ms_q + MS_W'(1);
			if (hold_lock || hold_unlock)
				hold_done_q <= 1'b1;
		end
	end

	// ****************************************************************
	// inactivity timer
	// ****************************************************************
	// counts ms since the last button activity; restarts on re-enable
	logic [MS_W-1:0] idle_ms_q;
	logic            activity;
	assign activity = press_evt | lock_db_q | hold_unlock;
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			idle_ms_q <= '0;
		else if (activity || state_q == PLRS_LOCKED)
			idle_ms_q <= '0;
		else if (tick_q && idle_ms_q != '1)
			idle_ms_q <= idle_ms_q + MS_W'(1);
	end
	logic timeout_hit;
	logic fan_hit;
	assign timeout_hit = (timeout_ms != 32'h0) && (idle_ms_q >= timeout_ms);
	assign fan_hit     = fan_s && (idle_ms_q >= MS_W'(FAN_MS));

	// fan warning onset locks the panel once
	logic fan_prev_q;
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			fan_prev_q <= 1'b0;
		else
			fan_prev_q <= fan_s;
	end

	// ****************************************************************
	// panel state
	// ****************************************************************
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			state_q <= PLRS_ENABLED;
		else
		begin
			case (state_q)
				PLRS_ENABLED:
				begin
					if (hold_lock || timeout_hit)
						state_q <= PLRS_LOCKED;
					else if ((fan_s && !fan_prev_q) || fan_hit)
						state_q <= PLRS_LOCKED;
				end
				PLRS_LOCKED:
				begin
					if (hold_unlock)
						state_q <= PLRS_ENABLED;
				end
				default:
					state_q <= PLRS_ENABLED;
			endcase
		end
	end

	// ****************************************************************
	// blink generator and lamps
	// ****************************************************************
	logic [15:0] blink_ms_q;
	logic        blink_q;
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			blink_ms_q <= 16'h0000;
			blink_q    <= 1'b0;
		end
		else if (tick_q)
		begin
			if (blink_ms_q >= 16'(BLINK_HALF_MS - 1))
			begin
				blink_ms_q <= 16'h0000;
				blink_q    <= ~blink_q;
			end
			else
				blink_ms_q <= blink_ms_q + 16'h0001;
		end
	end

	// lamps registered straight to the pins
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lamps         <= '0;
			panel_enabled <= 1'b0;
		end
		else
		begin
			panel_enabled           <= (state_q == PLRS_ENABLED);
			lamps.enable_lamp       <= (state_q == PLRS_ENABLED);
			lamps.internal_ref_lamp <= ~ref_s.ext_selected;
			if (ref_s.ext_selected && ref_s.ext_locked)
				lamps.external_ref_lamp <= 1'b1;
			else if (ref_s.ext_selected)
				lamps.external_ref_lamp <= blink_q;
			else
				lamps.external_ref_lamp <= 1'b0;
		end
	end

endmodule // plrs_panel_lockout

// ---- plrs_panel_lockout_monitor.sv ----
// assertion checker for the panel lockout ports
`timescale 1ns/1ps
module plrs_panel_lockout_monitor
	import plrs_pkg::*;
#(
	parameter int unsigned LOCK_MS   = LOCK_HOLD_MS,
	parameter int unsigned UNLOCK_MS = UNLOCK_HOLD_MS,
	parameter int unsigned TICK_CYC  = TICK_CYCLES
)
(
	// all ports of the block
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic        lock_button,
	input wire logic        any_button,
	input wire logic [31:0] timeout_ms,
	input wire logic        fan_fail,
	input wire plrs_ref_t   ref_status,
	input wire plrs_lamps_t lamps,
	input wire logic        panel_enabled
);
	// ****
	// run counters
	// ****
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	logic [31:0] run_q;      // length of the latest raw press run
	logic [31:0] gap_q;      // cycles since the raw button was last high
	logic        btn_prev_q; // raw button one cycle back
	logic [31:0] en_q;    // enabled run
	logic [31:0] blink_q; // unchanged blink lamp run
	logic        live_q;  // enable out of reset already seen
	// the filter delays press and release alike, so the filtered hold matches
	// the raw run to within a tick; the bounds below leave room for that slack
	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
			{run_q, gap_q, btn_prev_q, en_q, blink_q, live_q} <= '0;
		else
		begin
			btn_prev_q <= lock_button;
			run_q   <= !lock_button ? run_q : (btn_prev_q ? run_q + 1 : 32'h1);
			gap_q   <= lock_button ? '0 : gap_q + 1;
			en_q    <= panel_enabled ? en_q + 1 : '0;
			blink_q <= (ref_status == 2'b10 && $stable(lamps.external_ref_lamp)) ? blink_q + 1 : '0;
			live_q  <= live_q | panel_enabled;
		end
	chk_lamp_tracks: assert property (
		lamps.enable_lamp == panel_enabled) else $error("enable lamp wrong");
	chk_int_lamp: assert property (
		$stable(ref_status) [*6] |-> lamps.internal_ref_lamp == !ref_status.ext_selected)
		else $error("internal lamp wrong");
	chk_ext_steady: assert property (
		$stable(ref_status) [*6] ##0 ref_status != 2'b10 |->
		lamps.external_ref_lamp == ref_status.ext_selected) else $error("ext lamp wrong");
	chk_ext_blink: assert property (
		blink_q <= BLINK_HALF_MS * TICK_CYC + 8) else $error("ext lamp not blinking");
	chk_lock_hold: assert property (
		$fell(panel_enabled) && !fan_fail && timeout_ms == 0 |->
		run_q >= (LOCK_MS - 2) * TICK_CYC && gap_q <= (DEBOUNCE_MS + 3) * TICK_CYC)
		else $error("early lock");
	chk_unlock_hold: assert property (
		$rose(panel_enabled) && live_q |->
		run_q >= (UNLOCK_MS - 2) * TICK_CYC && gap_q <= (DEBOUNCE_MS + 3) * TICK_CYC)
		else $error("early unlock");
	chk_tmo_restart: assert property (
		$fell(panel_enabled) && !fan_fail && timeout_ms != 0
		&& gap_q > (DEBOUNCE_MS + 3) * TICK_CYC |->
		en_q >= (timeout_ms - 1) * TICK_CYC) else $error("early timeout");
	chk_fan_edge: assert property (
		$rose(fan_fail) && panel_enabled |-> ##[1:8] !panel_enabled) else $error("fan no lock");
endmodule // plrs_panel_lockout_monitor
bind plrs_panel_lockout plrs_panel_lockout_monitor #(.LOCK_MS(LOCK_MS),
	.UNLOCK_MS(UNLOCK_MS), .TICK_CYC(TICK_CYC)) i_mon (.clock(clock), .sys_rst(sys_rst),
	.lock_button(lock_button), .any_button(any_button), .timeout_ms(timeout_ms),
	.fan_fail(fan_fail), .ref_status(ref_status), .lamps(lamps), .panel_enabled(panel_enabled));

// ---- plrs_panel_model.sv ----
// front panel model: bouncing lock button and other buttons
`timescale 1ns/1ps
module plrs_panel_model
(
	// bench requests
	input  wire logic        clock,
	input  wire logic        go,        // start a lock press
	input  wire logic [15:0] press_len, // one more than the cycles held after bounce
	input  wire logic        tap,       // one-cycle other press
	// panel pins
	output logic             lock_button,
	output logic             any_button,
	output logic             busy
);
	// ****
	// button drive
	// ****
	logic [15:0] cnt_q; // cycles left in the press
	initial
		{lock_button, any_button, busy, cnt_q} = '0;
	// six bounce edges open every press, as worn contacts do
	always @(posedge clock)
	begin
		any_button <= tap;
		if (go && !busy)
		begin
			busy  <= 1'b1;
			cnt_q <= press_len + 16'h6;
		end
		else if (busy)
		begin
			cnt_q       <= cnt_q - 16'h1;
			lock_button <= (cnt_q > press_len) ? ~lock_button : (cnt_q != 16'h1);
			busy        <= (cnt_q != 16'h1);
		end
	end
endmodule // plrs_panel_model

// ---- plrs_panel_lockout_tb.sv ----
// self-checking bench for the panel lockout block
`timescale 1ns/1ps
module plrs_panel_lockout_tb
	import plrs_pkg::*;
;
	// ****
	// bench state
	// ****
	localparam int TCK = 4; // cycles per ms tick, kept short
	logic        clock, sys_rst, fan_fail, go, tap, busy, last_en, ext_prev;
	logic        lock_button, any_button, panel_enabled;
	logic [31:0] timeout_ms;
	logic [15:0] press_len;
	plrs_ref_t   ref_status;
	plrs_lamps_t lamps;
	logic        exp_q[$]; // expected panel states, oldest first
	int          num_errors = 0, n_checks = 0, flips, ref_ofs;
	logic [1:0]  ref_v; // reference level applied in the lamp test
	// holds longer than the debounce time, so a filtered press can still be short
	plrs_panel_lockout #(.LOCK_MS(20), .UNLOCK_MS(40), .FAN_MS(20), .TICK_CYC(TCK)) i_dut (
		.clock(clock), .sys_rst(sys_rst), .lock_button(lock_button), .any_button(any_button),
		.timeout_ms(timeout_ms), .fan_fail(fan_fail), .ref_status(ref_status), .lamps(lamps),
		.panel_enabled(panel_enabled));
	plrs_panel_model i_panel (.clock(clock), .go(go), .press_len(press_len), .tap(tap),
		.lock_button(lock_button), .any_button(any_button), .busy(busy));
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic check(input logic exp, input logic got);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	// one press, then time for the released contact to settle
	task automatic press(input int len);
		press_len <= 16'(len);
		go        <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		@(posedge clock);
		for (int i = 0; i < 999 && busy; i++)
			@(posedge clock);
		repeat (60) @(posedge clock);
	endtask
	// wait until at most k notes are pending
	task automatic drain(input int n, input int k);
		for (int i = 0; i < n && exp_q.size() > k; i++)
			@(posedge clock);
		check(1'b1, exp_q.size() <= k);
	endtask
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// each panel state change takes the oldest note
	always @(negedge clock)
		if (sys_rst)
			last_en = panel_enabled;
		else if (panel_enabled !== last_en)
		begin
			last_en = panel_enabled;
			check(exp_q.size() ? exp_q.pop_front() : ~last_en, last_en);
		end
	initial
	begin
		#300_000;
		num_errors++;
		complete_run();
	end
	initial
	begin
		void'($urandom(32'hDEC922C3));
		{sys_rst, fan_fail, go, tap, timeout_ms, press_len, ref_status} = '0;
		sys_rst = 1'b1;
		exp_q.push_back(1'b1);
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		drain(20, 0);
		press(8);
		press(50 + $urandom % 20);
		$display("test reset and short press done");
		exp_q.push_back(1'b0);
		press(120 + $urandom % 40);
		press(60 + $urandom % 60);
		timeout_ms <= 32'h4 + $urandom % 4;
		exp_q.push_back(1'b1);
		exp_q.push_back(1'b0);
		press(180 + $urandom % 40);
		drain(400, 0);
		timeout_ms <= '0;
		$display("test lock and timeout done");
		exp_q.push_back(1'b1);
		press(180 + $urandom % 40);
		exp_q.push_back(1'b0);
		fan_fail <= 1'b1;
		drain(20, 0);
		exp_q.push_back(1'b1);
		exp_q.push_back(1'b0);
		press(180 + $urandom % 40);
		tap <= 1'b1;
		@(posedge clock);
		tap <= 1'b0;
		// the tap restarted the idle count, so the relock is not yet due
		repeat (76) @(negedge clock);
		check(1'b1, panel_enabled);
		drain(20 * TCK + 200, 0);
		fan_fail <= 1'b0;
		$display("test fan warning done");
		// reset in mid-run: a locked panel comes back enabled
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clock);
		exp_q.push_back(1'b1);
		sys_rst <= 1'b0;
		drain(20, 0);
		$display("test mid-run reset done");
		ref_ofs = $urandom % 4;
		for (int s = 0; s < 4; s++)
		begin
			@(posedge clock);
			ref_v = 2'(s + ref_ofs);
			ref_status <= ref_v;
			repeat (8) @(negedge clock);
			check(~ref_v[1], lamps.internal_ref_lamp);
			flips = 0;
			ext_prev = lamps.external_ref_lamp;
			repeat (2200)
			begin
				@(negedge clock);
				flips += int'(lamps.external_ref_lamp !== ext_prev);
				ext_prev = lamps.external_ref_lamp;
			end
			check(ref_v == 2'b10, flips > 1);
			if (ref_v != 2'b10)
				check(ref_v == 2'b11, lamps.external_ref_lamp);
		end
		$display("test reference lamps done");
		complete_run();
	end
endmodule // plrs_panel_lockout_tb
